// file: rtl/coc_top.sv
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module coc_top (
  input  wire logic        clock_i,
  input  wire logic        rst_i,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Command word stream, 16-bit words, header first
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  input  wire logic [15:0] cmd_data_i,
  input  wire logic        cmd_last_i,
  output logic             cmd_accept_o,
  output logic             cmd_reject_o,
  // Raw continuum samples
  input  wire logic        sample_valid_i,
  input  wire logic [15:0] mm_sample_i,
  input  wire logic [15:0] submm_sample_i,
  // Reduced samples to the summing stage
  output logic             red_valid_o,
  output logic      [15:0] mm_reduced_o,
  output logic      [15:0] submm_reduced_o,
  output logic             mm_over_o,
  output logic             submm_over_o,
  // Telemetry packet opening
  input  wire logic        pkt_open_i,
  output logic      [15:0] mm_offset_parameter_o,
  output logic      [15:0] submm_offset_parameter_o
);
  typedef enum logic [1:0] {ST_RECV, ST_DROP} coc_state_e;

  coc_state_e  state_ff;
  logic [3:0]  idx_ff;
  logic        bad_ff;
  logic [15:0] sum_ff;
  logic [15:0] data_hi_ff;
  logic [15:0] data_lo_ff;
  logic [15:0] mm_off_ff;
  logic [15:0] submm_off_ff;
  logic        enable_ff;
  logic [15:0] acc_cnt_ff;
  logic [15:0] rej_cnt_ff;
  logic        accept_ff;
  logic        reject_ff;
  logic        f_valid;
  logic        f_ready;
  logic [15:0] f_data;
  logic        f_last;
  logic        fifo_in_ready;
  logic        word_ok;
  logic        take;
  logic        chk_ok;
  logic        hdr_ok;
  logic        last_q;

  function automatic logic [15:0] coc_reduce(input logic [15:0] raw, input logic [15:0] off);
    // Clamp so an oversized offset cannot wrap into a huge value
    return (raw > off) ? (raw - off) : 16'h0000;
  endfunction

  // Words buffered ahead of the parser; last marker carried via a side bit
  coc_fifo #(.WIDTH(coc_pkg::FIFO_WIDTH + 1), .DEPTH(coc_pkg::FIFO_DEPTH)) u_fifo (
    .clock_i     (clock_i),
    .rst_i       (rst_i),
    .in_valid_i  (cmd_valid_i),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({cmd_last_i, cmd_data_i}),
    .out_valid_o (f_valid),
    .out_ready_i (f_ready),
    .out_data_o  ({f_last, f_data})
  );
  assign cmd_ready_o = fifo_in_ready;
  // Parser stalls while disabled so the buffer really fills
  assign f_ready     = enable_ff;
  assign take        = f_valid && f_ready;

  always_comb begin
    case (idx_ff)
      4'd0: word_ok = (f_data == coc_pkg::HDR0_VALUE);
      4'd1: word_ok = ((f_data & coc_pkg::HDR1_FLAG_MASK) == coc_pkg::HDR1_FLAG_VAL) &&
                      ((f_data & coc_pkg::HDR1_SRC_MASK) == 16'h0000);
      4'd2: word_ok = (f_data == coc_pkg::LEN_VALUE);
      4'd3: word_ok = (f_data == coc_pkg::HDR3_VALUE) &&
                      (f_data[11:8] == coc_pkg::ACK_ACCEPT);
      4'd4: word_ok = (f_data == coc_pkg::HDR4_VALUE);
      default: word_ok = 1'b1;
    endcase
  end

  assign hdr_ok = !bad_ff && word_ok;
  // trailing check is the 16-bit sum of all prior words
  assign chk_ok = (f_data == sum_ff);
  assign last_q = take && (idx_ff == 4'(coc_pkg::PKT_WORDS - 1));

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_ff <= ST_RECV;
      idx_ff   <= 4'h0;
      bad_ff   <= 1'b0;
      sum_ff   <= 16'h0000;
    end else if (take) begin
      case (state_ff)
        ST_RECV: begin
          if (last_q || f_last) begin
            idx_ff <= 4'h0;
            bad_ff <= 1'b0;
            sum_ff <= 16'h0000;
            // Extra words past the packet end are flushed up to the marker
            if (!f_last) begin
              state_ff <= ST_DROP;
            end
          end else begin
            idx_ff <= idx_ff + 4'h1;
            bad_ff <= !hdr_ok;
            sum_ff <= sum_ff + f_data;
          end
        end
        ST_DROP: begin
          if (f_last) begin
            state_ff <= ST_RECV;
          end
        end
        default: state_ff <= ST_RECV;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      data_hi_ff <= 16'h0000;
      data_lo_ff <= 16'h0000;
    end else if (take && state_ff == ST_RECV) begin
      if (idx_ff == 4'd5) begin
        data_hi_ff <= f_data;
      end
      if (idx_ff == 4'd6) begin
        data_lo_ff <= f_data;
      end
    end
  end

  // the offsets change only on acceptance, which also pulses accept_ff
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mm_off_ff    <= coc_pkg::OFFSET_RESET;
      submm_off_ff <= coc_pkg::OFFSET_RESET;
      accept_ff    <= 1'b0;
      reject_ff    <= 1'b0;
    end else begin
      accept_ff <= 1'b0;
      reject_ff <= 1'b0;
      if (take && state_ff == ST_RECV && (last_q || f_last)) begin
        // A frame longer than its length field is refused as a whole
        if (last_q && f_last && !bad_ff && chk_ok) begin
          mm_off_ff    <= data_hi_ff;
          submm_off_ff <= data_lo_ff;
          accept_ff    <= 1'b1;
        end else begin
          reject_ff <= 1'b1;
        end
      end
    end
  end
  assign cmd_accept_o = accept_ff;
  assign cmd_reject_o = reject_ff;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      red_valid_o     <= 1'b0;
      mm_reduced_o    <= 16'h0000;
      submm_reduced_o <= 16'h0000;
      mm_over_o       <= 1'b0;
      submm_over_o    <= 1'b0;
    end else begin
      red_valid_o <= sample_valid_i;
      if (sample_valid_i) begin
        mm_reduced_o    <= coc_reduce(mm_sample_i, mm_off_ff);
        submm_reduced_o <= coc_reduce(submm_sample_i, submm_off_ff);
        // flag samples above the representable ceiling
        mm_over_o       <= coc_reduce(mm_sample_i, mm_off_ff) > coc_pkg::CONT_MAX;
        submm_over_o    <= coc_reduce(submm_sample_i, submm_off_ff) > coc_pkg::CONT_MAX;
      end
    end
  end

  // held from packet open until the next open, any duration
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      mm_offset_parameter_o    <= coc_pkg::OFFSET_RESET;
      submm_offset_parameter_o <= coc_pkg::OFFSET_RESET;
    end else if (pkt_open_i) begin
      mm_offset_parameter_o    <= mm_off_ff;
      submm_offset_parameter_o <= submm_off_ff;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      enable_ff  <= 1'b1;
      acc_cnt_ff <= 16'h0000;
      rej_cnt_ff <= 16'h0000;
    end else begin
      if (avs_write && !avs_waitrequest && avs_address == coc_pkg::REG_CTRL &&
          avs_byteenable[0]) begin
        enable_ff <= avs_writedata[0];
      end
      if (accept_ff) begin
        acc_cnt_ff <= acc_cnt_ff + 16'h0001;
      end
      if (reject_ff) begin
        rej_cnt_ff <= rej_cnt_ff + 16'h0001;
      end
    end
  end

  // One wait cycle: the answer is registered
  logic rd_done_ff;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rd_done_ff   <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      rd_done_ff <= (avs_read || avs_write) && !rd_done_ff;
      if (avs_read && !rd_done_ff) begin
        case (avs_address)
          coc_pkg::REG_CTRL:     avs_readdata <= {31'h0, enable_ff};
          coc_pkg::REG_STATUS:   avs_readdata <= {29'h0, f_valid, !fifo_in_ready,
                                                  state_ff == ST_DROP};
          coc_pkg::REG_OFFSETS:  avs_readdata <= {mm_off_ff, submm_off_ff};
          coc_pkg::REG_CMD_WORD: avs_readdata <= {data_hi_ff, data_lo_ff};
          coc_pkg::REG_COUNTS:   avs_readdata <= {acc_cnt_ff, rej_cnt_ff};
          default:               avs_readdata <= coc_pkg::UNMAPPED_VALUE;
        endcase
      end
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !rd_done_ff;
endmodule
`default_nettype wire

// file: rtl/coc_pkg.sv
// Contract
// - Accept only packets with process id 1000111 and category 1100.
// - Length field equals data bytes plus five, nine here.
// - Ack field requests acceptance ack; device reports acceptance.
// - Packet type 11000000 marks a private command candidate.
// - Subtype fourteen selects offset command; only then load offsets.
// - Data holds mm offset first, then submm offset, each 16 bits.
// - Independent offsets kept for mm and submm channels.
// - Accepted offsets take effect for the very next sample.
// - Subtract held offset from every raw sample, one per 50 ms.
// - Subtraction comes first; summing uses reduced samples only.
// - 32000 is the ceiling; larger sums are lost.
// - Offsets latched into telemetry when a packet opens, not rewritten.
// - Packet fill of 10 to 200 seconds is tolerated.
// - Offsets cleared to zero at reset.
// - Command leaves other registers and sensor data untouched.
`default_nettype none
package coc_pkg;
  localparam int          PKT_WORDS      = 8;
  localparam logic [15:0] HDR0_VALUE     = 16'h1c7c;
  localparam logic [15:0] HDR1_FLAG_MASK = 16'hc000;
  localparam logic [15:0] HDR1_FLAG_VAL  = 16'hc000;
  localparam logic [15:0] HDR1_SRC_MASK  = 16'h3800;
  localparam logic [15:0] LEN_VALUE      = 16'h0009;
  localparam logic [15:0] HDR3_VALUE     = 16'h11c0;
  localparam logic [15:0] HDR4_VALUE     = 16'h0e00;
  localparam logic [3:0]  ACK_ACCEPT     = 4'h1;
  localparam logic [15:0] CONT_MAX       = 16'h7d00;
  localparam logic [15:0] OFFSET_RESET   = 16'h0000;
  localparam int          SAMPLE_MS      = 50;
  localparam int          FILL_MIN_S     = 10;
  localparam int          FILL_MAX_S     = 200;
  localparam logic [5:0]  REG_CTRL       = 6'h00;
  localparam logic [5:0]  REG_STATUS     = 6'h04;
  localparam logic [5:0]  REG_OFFSETS    = 6'h08;
  localparam logic [5:0]  REG_CMD_WORD   = 6'h0c;
  localparam logic [5:0]  REG_COUNTS     = 6'h10;
  localparam logic [31:0] UNMAPPED_VALUE = 32'hdeadbeef;
  localparam int          FIFO_WIDTH     = 16;
  localparam int          FIFO_DEPTH     = 32;
endpackage
`default_nettype wire

// file: rtl/coc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module coc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clock_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff;
  logic [AW-1:0]    rd_ff;
  logic [AW:0]      cnt_ff;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_ff != '0);
  assign out_data_o  = mem_ff[rd_ff];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge clock_i) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// file: dv/coc_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module coc_top_chk (
  input wire logic        clock_i,
  input wire logic        rst_i,
  input wire logic        avs_read,
  input wire logic        avs_waitrequest,
  input wire logic        sample_valid_i,
  input wire logic [15:0] mm_sample_i,
  input wire logic [15:0] submm_sample_i,
  input wire logic        red_valid_o,
  input wire logic [15:0] mm_reduced_o,
  input wire logic [15:0] submm_reduced_o,
  input wire logic        mm_over_o,
  input wire logic        cmd_accept_o,
  input wire logic        cmd_reject_o,
  input wire logic        pkt_open_i,
  input wire logic [15:0] mm_offset_parameter_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_read_one_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read not answered after one wait cycle");
  a_red_one_late: assert property (sample_valid_i |=> red_valid_o)
    else $error("reduced sample missing");
  a_red_has_cause: assert property (red_valid_o |-> $past(sample_valid_i))
    else $error("reduced sample without raw sample");
  a_mm_no_wrap: assert property (red_valid_o |-> mm_reduced_o <= $past(mm_sample_i))
    else $error("mm reduced value wrapped");
  a_submm_no_wrap: assert property (red_valid_o |-> submm_reduced_o <= $past(submm_sample_i))
    else $error("submm reduced value wrapped");
  a_over_ceiling: assert property (red_valid_o |-> mm_over_o == (mm_reduced_o > 16'h7d00))
    else $error("mm over flag wrong");
  a_param_frozen: assert property (!pkt_open_i |=> $stable(mm_offset_parameter_o))
    else $error("telemetry offset changed without packet open");
  a_one_verdict: assert property (!(cmd_accept_o && cmd_reject_o))
    else $error("accept and reject together");
  a_accept_pulse: assert property (cmd_accept_o |=> !cmd_accept_o)
    else $error("accept longer than one cycle");
  c_accept: cover property (cmd_accept_o);
  c_reject: cover property (cmd_reject_o);
  c_over: cover property (red_valid_o && mm_over_o);
endmodule
bind coc_top coc_top_chk coc_top_chk_inst (.clock_i(clock_i), .rst_i(rst_i),
  .avs_read(avs_read), .avs_waitrequest(avs_waitrequest), .sample_valid_i(sample_valid_i),
  .mm_sample_i(mm_sample_i), .submm_sample_i(submm_sample_i), .red_valid_o(red_valid_o),
  .mm_reduced_o(mm_reduced_o), .submm_reduced_o(submm_reduced_o), .mm_over_o(mm_over_o),
  .cmd_accept_o(cmd_accept_o), .cmd_reject_o(cmd_reject_o), .pkt_open_i(pkt_open_i),
  .mm_offset_parameter_o(mm_offset_parameter_o));
`default_nettype wire

// file: dv/coc_cmd_src.sv
`timescale 1ns/1ps
`default_nettype none
module coc_cmd_src (
  input  wire logic        clock_i,
  input  wire logic        cmd_ready_i,
  output logic             cmd_valid_o,
  output logic      [15:0] cmd_data_o,
  output logic             cmd_last_o
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_data_o  = 16'h0000;
    cmd_last_o  = 1'b0;
  end
  // Bad spoils one word; len other than 8 frames the packet wrongly
  task automatic send_cmd(input logic [15:0] mm, input logic [15:0] sm,
                          input logic [10:0] seq, input int bad, input int len);
    logic [15:0] w[8];
    logic [15:0] sum;
    int          i;
    int          t;
    w = '{16'h1c7c, {5'h18, seq}, 16'h0009, 16'h11c0, 16'h0e00, mm, sm, 16'h0000};
    if (bad >= 0 && bad < 7) w[bad] ^= 16'h0100;
    sum = 16'h0000;
    for (i = 0; i < 7; i++) sum += w[i];
    w[7] = (bad == 7) ? ~sum : sum;
    @(posedge clock_i);
    for (i = 0; i < len; i++) begin
      cmd_valid_o <= 1'b1;
      cmd_data_o  <= (i < 8) ? w[i] : 16'h5a5a;
      cmd_last_o  <= (i == len - 1);
      t = 0;
      do begin @(posedge clock_i); t++; end while (cmd_ready_i !== 1'b1 && t < 500);
      // A word never taken counts against the run
      if (t >= 500) continuum_offset_command_tb.n_errors++;
    end
    // Released data is inverted so a stale word cannot pass as valid
    cmd_valid_o <= 1'b0;
    cmd_data_o  <= ~cmd_data_o;
    cmd_last_o  <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: dv/continuum_offset_command_tb.sv
`timescale 1ns/1ps
`default_nettype none
module continuum_offset_command_tb;
  logic        clock_i, rst_i, avs_read, avs_write, avs_waitrequest;
  logic        cmd_valid_i, cmd_ready_o, cmd_last_i, cmd_accept_o, cmd_reject_o;
  logic        sample_valid_i, red_valid_o, mm_over_o, submm_over_o, pkt_open_i;
  logic [3:0]  avs_byteenable;
  logic [5:0]  avs_address;
  logic [15:0] cmd_data_i, mm_sample_i, submm_sample_i, mm_reduced_o, submm_reduced_o;
  logic [15:0] mm_offset_parameter_o, submm_offset_parameter_o, om, os;
  logic [31:0] avs_writedata, avs_readdata, q;
  int          n_errors, n_compared, i, sq;
  int          bads[6] = '{0, 2, 3, 4, 7, -1};
  coc_top coc_top_inst (.clock_i(clock_i), .rst_i(rst_i), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
    .cmd_data_i(cmd_data_i), .cmd_last_i(cmd_last_i), .cmd_accept_o(cmd_accept_o),
    .cmd_reject_o(cmd_reject_o), .sample_valid_i(sample_valid_i), .mm_sample_i(mm_sample_i),
    .submm_sample_i(submm_sample_i), .red_valid_o(red_valid_o), .mm_reduced_o(mm_reduced_o),
    .submm_reduced_o(submm_reduced_o), .mm_over_o(mm_over_o), .submm_over_o(submm_over_o),
    .pkt_open_i(pkt_open_i), .mm_offset_parameter_o(mm_offset_parameter_o),
    .submm_offset_parameter_o(submm_offset_parameter_o));
  coc_cmd_src coc_cmd_src_inst (.clock_i(clock_i), .cmd_ready_i(cmd_ready_o),
    .cmd_valid_o(cmd_valid_i), .cmd_data_o(cmd_data_i), .cmd_last_o(cmd_last_i));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic complete_run;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int t;
    @(posedge clock_i);
    avs_address   <= a;
    avs_writedata <= d;
    avs_byteenable <= wr ? 4'h1 : 4'hf;
    avs_read      <= !wr;
    avs_write     <= wr;
    t = 0;
    do begin @(posedge clock_i); t++; end while (avs_waitrequest !== 1'b0 && t < 50);
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (t >= 50) begin
      n_errors++;
      complete_run;
    end
  endtask
  task automatic wait_ans(input logic acc);
    int t;
    t = 0;
    do begin @(negedge clock_i); t++; end while (!(cmd_accept_o | cmd_reject_o) && t < 100);
    chk("verdict", {30'h0, cmd_reject_o, cmd_accept_o}, {30'h0, !acc, acc});
  endtask
  task automatic samp(input logic [15:0] m, input logic [15:0] s);
    logic [15:0] em;
    logic [15:0] es;
    em = (m > om) ? m - om : 16'h0000;
    es = (s > os) ? s - os : 16'h0000;
    @(posedge clock_i);
    sample_valid_i <= 1'b1;
    mm_sample_i    <= m;
    submm_sample_i <= s;
    @(posedge clock_i);
    sample_valid_i <= 1'b0;
    @(negedge clock_i);
    chk("mm_reduced", {red_valid_o, 15'h0, mm_reduced_o}, {1'b1, 15'h0, em});
    chk("submm_reduced", {16'h0, submm_reduced_o}, {16'h0, es});
    chk("over", {mm_over_o, submm_over_o}, {em > 16'h7d00, es > 16'h7d00});
  endtask
  task automatic popen(input logic [15:0] em, input logic [15:0] es);
    @(posedge clock_i);
    pkt_open_i <= 1'b1;
    @(posedge clock_i);
    pkt_open_i <= 1'b0;
    @(negedge clock_i);
    chk("params", {mm_offset_parameter_o, submm_offset_parameter_o}, {em, es});
  endtask
  task automatic load(input logic [15:0] m, input logic [15:0] s);
    coc_cmd_src_inst.send_cmd(m, s, sq[10:0], -1, 8);
    sq++;
    wait_ans(1'b1);
    om = m;
    os = s;
  endtask
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial begin
    #400000;
    n_errors++;
    complete_run;
  end
  initial begin
    {rst_i, avs_read, avs_write, sample_valid_i, pkt_open_i} = 5'h10;
    {avs_byteenable, avs_address, avs_writedata, q} = '0;
    {mm_sample_i, submm_sample_i, om, os} = '0;
    {n_errors, n_compared, sq} = '0;
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    bus(0, 6'h08, 0);
    chk("offsets", q, 32'h0);
    bus(0, 6'h00, 0);
    chk("ctrl", q, 32'h1);
    bus(0, 6'h3c, 0);
    chk("unmapped", q, 32'hdeadbeef);
    samp(16'h1b58, 16'h01f4);
    load(16'h03e8, 16'h0bb8);
    samp(16'h1b58, 16'h07d0);
    samp(16'h80e8, 16'h88b9);
    bus(0, 6'h08, 0);
    chk("offsets", q, {om, os});
    popen(om, os);
    load(16'h0005, 16'h0006);
    chk("params_held", {mm_offset_parameter_o, submm_offset_parameter_o}, 32'h03e80bb8);
    popen(om, os);
    for (i = 0; i < 6; i++) begin
      coc_cmd_src_inst.send_cmd(16'hffff, 16'hffff, sq[10:0], bads[i], (i == 5) ? 7 : 8);
      sq++;
      wait_ans(1'b0);
      samp(16'h0010, 16'h0002);
    end
    bus(1, 6'h00, 32'h0);
    fork
      coc_cmd_src_inst.send_cmd(16'h0001, 16'h0001, sq[10:0], -1, 40);
      begin
        repeat (80) @(posedge clock_i);
        chk("fifo_full", {31'h0, cmd_ready_o}, 32'h0);
        bus(1, 6'h00, 32'h1);
        wait_ans(1'b0);
      end
    join
    bus(0, 6'h10, 0);
    chk("counts", q, 32'h00020007);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    bus(0, 6'h08, 0);
    chk("offsets_restart", q, 32'h0);
    chk("params_restart", {mm_offset_parameter_o, submm_offset_parameter_o}, 32'h0);
    complete_run;
  end
endmodule
`default_nettype wire
